// *** shared/omc_defines.svh ***
/*
 * Offsets, field positions, reset values and counts of the operating
 * mode controller. Assumes 32-bit AHB-Lite words, byte offsets below.
 */
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH

// Register byte offsets
`define OMC_OFS_MODE 8'h00
`define OMC_OFS_CFG 8'h04
`define OMC_OFS_PERI 8'h08
`define OMC_OFS_STAT 8'h0C

// Mode control register fields
`define OMC_BIT_HI_STOP 1
`define OMC_BIT_SLOW_SEL 2
`define OMC_BIT_SLEEP 3
`define OMC_BIT_GREEN 4

// Configuration register fields
`define OMC_BIT_OSC_LO 0
`define OMC_BIT_OSC_HI 1
`define OMC_BIT_RTC 2

// Peripheral enable register fields
`define OMC_BIT_BT_EN 0
`define OMC_BIT_TC_EN 1
`define OMC_BIT_CONV_EN 2
`define OMC_BIT_PWM_LO 3
`define OMC_BIT_PWM_HI 5

// Status register fields
`define OMC_BIT_CPUM_LO 0
`define OMC_BIT_CPUM_HI 1
`define OMC_BIT_SLOW_ACT 2
`define OMC_BIT_CPU_RUN 3
`define OMC_BIT_HI_ON 4
`define OMC_BIT_WARM 5
`define OMC_BIT_WAKE_P0 6
`define OMC_BIT_WAKE_BT 7

// Reset values
`define OMC_RST_HI_STOP 1'h0
`define OMC_RST_SLOW_SEL 1'h0
`define OMC_RST_SLEEP 1'h0
`define OMC_RST_GREEN 1'h0
`define OMC_RST_CFG 3'h0
`define OMC_RST_PERI 6'h00

// CPU operating mode codes
`define OMC_CPUM_NORMAL 2'h0
`define OMC_CPUM_DOWN 2'h1
`define OMC_CPUM_GREEN 2'h2

// Counts in oscillator cycles
`define OMC_WARM_XTAL 12'h800
`define OMC_WARM_RC 12'h020
`define OMC_SLOW_DIV_LAST 2'h3

`endif

// *** shared/omc_pkg.sv ***
/*
 * Types of the operating mode controller.
 * Assumes omc_defines.svh carries all numbers.
 */
package omc_pkg;
	// Gray codes along normal, slow, green, down, warm-up
	typedef enum logic [2:0] {
		OMC_ST_NORMAL = 3'h0,
		OMC_ST_SLOW = 3'h1,
		OMC_ST_GREEN = 3'h3,
		OMC_ST_DOWN = 3'h2,
		OMC_ST_WARM = 3'h6
	} omc_state_e;

	typedef enum logic [1:0] {
		OMC_OSC_IFAST = 2'h0,
		OMC_OSC_ERC = 2'h1,
		OMC_OSC_XTAL = 2'h2,
		OMC_OSC_RSV = 2'h3
	} omc_osc_e;

	typedef enum logic [1:0] {
		OMC_WU_IDLE = 2'h0,
		OMC_WU_START = 2'h1,
		OMC_WU_COUNT = 2'h3
	} omc_warm_e;
endpackage

// *** shared/omc_warm_if.sv ***
/*
 * Carrier between the mode controller and its warm-up counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface omc_warm_if;
	logic ce;
	logic start;
	logic crystal;
	logic osc_edge;
	logic osc_stable;
	logic busy;
	logic done;

	modport ctrl (
		output ce, start, crystal, osc_edge, osc_stable,
		input busy, done
	);
	modport warm (
		input ce, start, crystal, osc_edge, osc_stable,
		output busy, done
	);
endinterface

// *** rtl/omc_warmup.sv ***
/*
 * Warm-up counter: after a start pulse waits for oscillator start-up,
 * then counts high oscillator edges. Assumes edges and start-up flag
 * are already synchronised to clk.
 */
`timescale 1ns/10ps
module omc_warmup
	import omc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Controller side
	omc_warm_if.warm w
);
	`include "omc_defines.svh"

	omc_warm_e state;
	logic [11:0] cnt;
	logic [11:0] target;

	assign target = w.crystal ? `OMC_WARM_XTAL : `OMC_WARM_RC;
	assign w.busy = (state != OMC_WU_IDLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= OMC_WU_IDLE;
			cnt <= 12'h000;
			w.done <= 1'b0;
		end else if (w.ce) begin
			w.done <= 1'b0;
			case (state)
				OMC_WU_IDLE: begin
					cnt <= 12'h000;
					if (w.start) begin
						state <= OMC_WU_START;
					end
				end
				// R16 R17: start-up first
				OMC_WU_START: begin
					if (w.osc_stable) begin
						state <= OMC_WU_COUNT;
					end
				end
				// R16 R17: then the cycle count
				OMC_WU_COUNT: begin
					if (w.osc_edge) begin
						if (cnt == target - 12'h001) begin
							state <= OMC_WU_IDLE;
							w.done <= 1'b1;
						end else begin
							cnt <= cnt + 12'h001;
						end
					end
				end
				default: begin
					state <= OMC_WU_IDLE;
				end
			endcase
		end
	end
endmodule

// *** rtl/omc_top.sv ***
/*
 * Operating mode controller: normal, slow, green and power down modes,
 * oscillator enables, CPU run and peripheral gating, wake-up and
 * oscillator warm-up. Registers over AHB-Lite, zero wait states.
 * Assumes oscillator levels and P0 pins are asynchronous to CLK_IN,
 * basic timer overflow comes from logic on CLK_IN, and CLK_IN itself
 * is an always-on clock that keeps running in power down.
 */
// The implementer's own choices: the AHB-Lite slave port and the register addresses.

// How it works
// R1: Normal: CPU on high clock, both oscillators on, peripherals by enable.
// R2: Any released reset starts the controller in normal mode.
// R3: Slow clock select 1 picks slow mode, 0 picks normal mode.
// R4: Slow mode instruction tick is slow oscillator divided by four.
// R5: Slow mode keeps high oscillator on unless high oscillator stop set.
// R6: Software sets high oscillator stop after entering slow mode.
// R7: Sleep request 1: power down; CPU, timers, PWM, ADC, interrupts off.
// R8: Power down stops every oscillator, slow RC included.
// R9: Power down exits only on P0 change or reset, always to normal.
// R10: Wake from power down clears the sleep request bit.
// R11: Green request 1 enters green mode; bit clears on wake.
// R12: Green halts CPU, keeps clock; timers by enable, ADC off, basic only.
// R13: Green wakes on P0 change or basic timer overflow, to prior mode.
// R14: Green keeps counter timer PWM running; its overflow never wakes.
// R15: High oscillator stop in normal mode acts as power down.
// R16: Crystal wake waits start-up plus 2048 oscillator cycles.
// R17: RC wake waits start-up plus 32 oscillator cycles.
// R18: Green wake resumes with no warm-up delay.
// R19: Software re-enables and warms high oscillator before leaving slow.
// R20: Mode field codes normal 00, power down 01, green 10.
// R21: High oscillator stop hits the configured fast source only.
// R22: P0 change compares synchronised pins with values caught at entry.
`timescale 1ns/10ps
module omc_top
	import omc_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CE_IN,
	// AHB-Lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	// Oscillator observation
	input wire logic HI_OSC_LVL_IN,
	input wire logic LO_OSC_LVL_IN,
	input wire logic HI_OSC_STABLE_IN,
	// Wake sources
	input wire logic [7:0] P0_IN,
	input wire logic BASIC_TIMER_OVF_IN,
	// Oscillator enables
	output logic EXT_FAST_OSC_EN_OUT,
	output logic INT_FAST_RC_EN_OUT,
	output logic INT_SLOW_RC_EN_OUT,
	// CPU control
	output logic CPU_RUN_OUT,
	output logic CPU_CLK_SLOW_OUT,
	output logic CPU_TICK_OUT,
	// Peripheral gating
	output logic BASIC_TIMER_RUN_OUT,
	output logic TIMER_COUNTER_RUN_OUT,
	output logic [2:0] PWM_RUN_OUT,
	output logic CONVERTER_RUN_OUT,
	output logic [2:0] INT_ALLOW_OUT,
	output logic EXT_INT_ALLOW_OUT
);
	`include "omc_defines.svh"

	logic rst_meta;
	logic rst_n;
	omc_state_e state;
	logic hi_osc_stop;
	logic slow_clock_select;
	logic sleep_request;
	logic green_request;
	logic [2:0] cfg;
	logic [5:0] peri;
	logic [1:0] wake_cause;
	logic [7:0] p0_meta;
	logic [7:0] p0_sync;
	logic [7:0] p0_ref;
	logic [2:0] osc_meta;
	logic [2:0] osc_sync;
	logic hi_prev;
	logic lo_prev;
	logic hi_edge;
	logic lo_edge;
	logic p0_change;
	logic [1:0] slow_div;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic addr_ok;
	logic wr_mode;
	logic wr_cfg;
	logic wr_peri;
	logic enter_down;
	logic enter_green;
	logic wake_down;
	logic wake_green;
	logic hi_on;
	logic [1:0] cpum;
	logic [31:0] rd_mux;
	omc_osc_e osc_type;
	omc_warm_if wu ();

	// R2: released through two flip-flops
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Pin synchronisers; edge detect reads second stage only
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			p0_meta <= 8'h00;
			p0_sync <= 8'h00;
			osc_meta <= 3'h0;
			osc_sync <= 3'h0;
			hi_prev <= 1'b0;
			lo_prev <= 1'b0;
		end else if (CE_IN) begin
			p0_meta <= P0_IN;
			p0_sync <= p0_meta;
			osc_meta <= {HI_OSC_STABLE_IN, LO_OSC_LVL_IN, HI_OSC_LVL_IN};
			osc_sync <= osc_meta;
			hi_prev <= osc_sync[0];
			lo_prev <= osc_sync[1];
		end
	end

	assign hi_edge = osc_sync[0] & ~hi_prev;
	assign lo_edge = osc_sync[1] & ~lo_prev;
	// R22: compare against entry snapshot
	assign p0_change = (p0_sync != p0_ref);
	assign osc_type = omc_osc_e'(cfg[`OMC_BIT_OSC_HI:`OMC_BIT_OSC_LO]);

	// Bus address phase decode
	assign addr_ok = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	assign wr_mode = wr_pend & (wr_addr == `OMC_OFS_MODE);
	assign wr_cfg = wr_pend & (wr_addr == `OMC_OFS_CFG);
	assign wr_peri = wr_pend & (wr_addr == `OMC_OFS_PERI);
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			HRDATA_OUT <= 32'h0000_0000;
		end else if (CE_IN) begin
			wr_pend <= addr_ok & HWRITE_IN;
			wr_addr <= HADDR_IN[7:0];
			if (addr_ok & ~HWRITE_IN) begin
				HRDATA_OUT <= rd_mux;
			end
		end
	end

	// Transition conditions
	// R7 R11: requests act only while executing
	assign enter_down = ((state == OMC_ST_NORMAL) ||
		(state == OMC_ST_SLOW)) && (sleep_request ||
		// R15: normal mode with no high clock
		(state == OMC_ST_NORMAL && hi_osc_stop));
	assign enter_green = ((state == OMC_ST_NORMAL) ||
		(state == OMC_ST_SLOW)) && green_request && !enter_down;
	// R9: only P0 leaves power down
	assign wake_down = (state == OMC_ST_DOWN) && p0_change;
	// R13 R14: counter timer overflow is not a source
	assign wake_green = (state == OMC_ST_GREEN) &&
		(p0_change || BASIC_TIMER_OVF_IN);

	// Mode control bits; a software set wins over a hardware clear
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			hi_osc_stop <= `OMC_RST_HI_STOP;
			slow_clock_select <= `OMC_RST_SLOW_SEL;
			sleep_request <= `OMC_RST_SLEEP;
			green_request <= `OMC_RST_GREEN;
		end else if (CE_IN) begin
			if (wr_mode) begin
				slow_clock_select <= HWDATA_IN[`OMC_BIT_SLOW_SEL];
			end
			// Cleared on power down wake, else it would stop again
			if (wr_mode && HWDATA_IN[`OMC_BIT_HI_STOP]) begin
				hi_osc_stop <= 1'b1;
			end else if (wake_down || wr_mode) begin
				hi_osc_stop <= 1'b0;
			end
			// R10: cleared on power down wake
			if (wr_mode && HWDATA_IN[`OMC_BIT_SLEEP]) begin
				sleep_request <= 1'b1;
			end else if (wake_down || wr_mode) begin
				sleep_request <= 1'b0;
			end
			// R11: cleared on green wake; reserved 11 keeps sleep only
			if (wr_mode && HWDATA_IN[`OMC_BIT_GREEN] &&
				!HWDATA_IN[`OMC_BIT_SLEEP]) begin
				green_request <= 1'b1;
			end else if (wake_green || wr_mode) begin
				green_request <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `OMC_RST_CFG;
			peri <= `OMC_RST_PERI;
		end else if (CE_IN) begin
			if (wr_cfg) begin
				cfg <= HWDATA_IN[`OMC_BIT_RTC:`OMC_BIT_OSC_LO];
			end
			if (wr_peri) begin
				peri <= HWDATA_IN[`OMC_BIT_PWM_HI:`OMC_BIT_BT_EN];
			end
		end
	end

	// Mode state machine
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			// R2: normal after reset
			state <= OMC_ST_NORMAL;
		end else if (CE_IN) begin
			case (state)
				OMC_ST_NORMAL: begin
					if (enter_down) begin
						state <= OMC_ST_DOWN;
					end else if (enter_green) begin
						state <= OMC_ST_GREEN;
					// R3: select bit picks slow
					end else if (slow_clock_select) begin
						state <= OMC_ST_SLOW;
					end
				end
				OMC_ST_SLOW: begin
					if (enter_down) begin
						state <= OMC_ST_DOWN;
					end else if (enter_green) begin
						state <= OMC_ST_GREEN;
					// R3: cleared bit returns to normal
					end else if (!slow_clock_select) begin
						state <= OMC_ST_NORMAL;
					end
				end
				OMC_ST_GREEN: begin
					// R13 R18: prior mode, no warm-up
					if (wake_green) begin
						state <= slow_clock_select ? OMC_ST_SLOW
							: OMC_ST_NORMAL;
					end
				end
				OMC_ST_DOWN: begin
					// R9: always towards normal
					if (wake_down) begin
						state <= OMC_ST_WARM;
					end
				end
				OMC_ST_WARM: begin
					// R16 R17: resume after warm-up
					if (wu.done) begin
						state <= OMC_ST_NORMAL;
					end
				end
				default: begin
					state <= OMC_ST_NORMAL;
				end
			endcase
		end
	end

	// R22: snapshot taken on the entry cycle
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			p0_ref <= 8'h00;
			wake_cause <= 2'h0;
		end else if (CE_IN) begin
			if (enter_down || enter_green) begin
				p0_ref <= p0_sync;
			end else if (state != OMC_ST_DOWN &&
				state != OMC_ST_GREEN) begin
				p0_ref <= p0_sync;
			end
			if (wake_down || wake_green) begin
				wake_cause <= {BASIC_TIMER_OVF_IN & ~p0_change, p0_change};
			end
		end
	end

	// Warm-up counter
	assign wu.ce = CE_IN;
	assign wu.start = wake_down;
	assign wu.crystal = (osc_type == OMC_OSC_XTAL);
	assign wu.osc_edge = hi_edge;
	assign wu.osc_stable = osc_sync[2];

	omc_warmup u_warm (
		.clk(CLK_IN),
		.rst_n(rst_n),
		.w(wu.warm)
	);

	// R1 R5 R8: fast source on unless stopped or powered down; RTC keeps it on in green
	always_comb begin
		case (state)
			OMC_ST_NORMAL: hi_on = !hi_osc_stop;
			OMC_ST_SLOW: hi_on = !hi_osc_stop;
			// Real-time clock option keeps the source in green
			OMC_ST_GREEN: hi_on = !hi_osc_stop || cfg[`OMC_BIT_RTC];
			OMC_ST_WARM: hi_on = 1'b1;
			default: hi_on = 1'b0;
		endcase
	end

	// R20: mode field codes
	always_comb begin
		case (state)
			OMC_ST_GREEN: cpum = `OMC_CPUM_GREEN;
			OMC_ST_DOWN: cpum = `OMC_CPUM_DOWN;
			OMC_ST_WARM: cpum = `OMC_CPUM_DOWN;
			default: cpum = `OMC_CPUM_NORMAL;
		endcase
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (HADDR_IN[7:0])
			`OMC_OFS_MODE: begin
				rd_mux[`OMC_BIT_HI_STOP] = hi_osc_stop;
				rd_mux[`OMC_BIT_SLOW_SEL] = slow_clock_select;
				rd_mux[`OMC_BIT_SLEEP] = sleep_request;
				rd_mux[`OMC_BIT_GREEN] = green_request;
			end
			`OMC_OFS_CFG: rd_mux[`OMC_BIT_RTC:`OMC_BIT_OSC_LO] = cfg;
			`OMC_OFS_PERI: rd_mux[`OMC_BIT_PWM_HI:`OMC_BIT_BT_EN] = peri;
			`OMC_OFS_STAT: begin
				rd_mux[`OMC_BIT_CPUM_HI:`OMC_BIT_CPUM_LO] = cpum;
				rd_mux[`OMC_BIT_SLOW_ACT] = (state == OMC_ST_SLOW);
				rd_mux[`OMC_BIT_CPU_RUN] = CPU_RUN_OUT;
				rd_mux[`OMC_BIT_HI_ON] = hi_on;
				rd_mux[`OMC_BIT_WARM] = wu.busy;
				rd_mux[`OMC_BIT_WAKE_BT:`OMC_BIT_WAKE_P0] = wake_cause;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Registered control outputs
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			EXT_FAST_OSC_EN_OUT <= 1'b0;
			INT_FAST_RC_EN_OUT <= 1'b1;
			INT_SLOW_RC_EN_OUT <= 1'b1;
			CPU_RUN_OUT <= 1'b0;
			CPU_CLK_SLOW_OUT <= 1'b0;
			BASIC_TIMER_RUN_OUT <= 1'b0;
			TIMER_COUNTER_RUN_OUT <= 1'b0;
			PWM_RUN_OUT <= 3'h0;
			CONVERTER_RUN_OUT <= 1'b0;
			INT_ALLOW_OUT <= 3'h0;
			EXT_INT_ALLOW_OUT <= 1'b0;
		end else if (CE_IN) begin
			// R21: stop acts on the configured fast source only
			EXT_FAST_OSC_EN_OUT <= hi_on && (osc_type != OMC_OSC_IFAST);
			INT_FAST_RC_EN_OUT <= hi_on && (osc_type == OMC_OSC_IFAST);
			// R8: slow RC stops only in power down
			INT_SLOW_RC_EN_OUT <= (state != OMC_ST_DOWN);
			// R12 R7: no execution in green or power down
			CPU_RUN_OUT <= (state == OMC_ST_NORMAL) ||
				(state == OMC_ST_SLOW);
			CPU_CLK_SLOW_OUT <= (state == OMC_ST_SLOW) ||
				(state == OMC_ST_GREEN && slow_clock_select);
			// R12 R14: timers and PWM by enable, off in power down
			BASIC_TIMER_RUN_OUT <= peri[`OMC_BIT_BT_EN] &&
				(cpum != `OMC_CPUM_DOWN);
			TIMER_COUNTER_RUN_OUT <= peri[`OMC_BIT_TC_EN] &&
				(cpum != `OMC_CPUM_DOWN);
			PWM_RUN_OUT <= (cpum != `OMC_CPUM_DOWN) ?
				peri[`OMC_BIT_PWM_HI:`OMC_BIT_PWM_LO] : 3'h0;
			// R1 R12: converter only while executing
			CONVERTER_RUN_OUT <= peri[`OMC_BIT_CONV_EN] &&
				(cpum == `OMC_CPUM_NORMAL) && (state != OMC_ST_WARM);
			// R12: green leaves the basic timer interrupt only
			case (state)
				OMC_ST_NORMAL: INT_ALLOW_OUT <= 3'h7;
				OMC_ST_SLOW: INT_ALLOW_OUT <= 3'h7;
				OMC_ST_GREEN: INT_ALLOW_OUT <= 3'h1;
				default: INT_ALLOW_OUT <= 3'h0;
			endcase
			EXT_INT_ALLOW_OUT <= (state == OMC_ST_NORMAL) ||
				(state == OMC_ST_SLOW) || (state == OMC_ST_GREEN);
		end
	end

	// Instruction tick: one high edge in normal, four slow edges in slow
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			slow_div <= 2'h0;
			CPU_TICK_OUT <= 1'b0;
		end else if (CE_IN) begin
			CPU_TICK_OUT <= 1'b0;
			if (state == OMC_ST_NORMAL) begin
				slow_div <= 2'h0;
				// R1: high oscillator drives the CPU
				CPU_TICK_OUT <= hi_edge;
			end else if (state == OMC_ST_SLOW) begin
				// R4: fixed divide by four
				if (lo_edge) begin
					if (slow_div == `OMC_SLOW_DIV_LAST) begin
						slow_div <= 2'h0;
						CPU_TICK_OUT <= 1'b1;
					end else begin
						slow_div <= slow_div + 2'h1;
					end
				end
			end else begin
				slow_div <= 2'h0;
			end
		end
	end
endmodule

// *** verification/omc_top_chk.sv ***
/* Checker on the ports of omc_top, bound at the foot of this file.
   Assumes one clock, CE_IN held high by the bench. */
`timescale 1ns/10ps
module omc_top_chk (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// Watched ports
	input wire logic BASIC_TIMER_OVF_IN,
	input wire logic EXT_FAST_OSC_EN_OUT,
	input wire logic INT_FAST_RC_EN_OUT,
	input wire logic INT_SLOW_RC_EN_OUT,
	input wire logic CPU_RUN_OUT,
	input wire logic CPU_CLK_SLOW_OUT,
	input wire logic CPU_TICK_OUT,
	input wire logic BASIC_TIMER_RUN_OUT,
	input wire logic TIMER_COUNTER_RUN_OUT,
	input wire logic [2:0] PWM_RUN_OUT,
	input wire logic CONVERTER_RUN_OUT,
	input wire logic [2:0] INT_ALLOW_OUT,
	input wire logic EXT_INT_ALLOW_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	logic [15:0] wake_cnt;
	logic green;
	assign green = !CPU_RUN_OUT && EXT_INT_ALLOW_OUT;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN)
			wake_cnt <= 16'h0000;
		else if (!INT_SLOW_RC_EN_OUT)
			wake_cnt <= 16'h0001;
		else if (wake_cnt != 16'h0000 && !CPU_RUN_OUT)
			wake_cnt <= wake_cnt + 16'h0001;
		else
			wake_cnt <= 16'h0000;
	end
	property p_rst;
		$rose(RST_B_IN) |-> ##3 (CPU_RUN_OUT && INT_FAST_RC_EN_OUT &&
			!CPU_CLK_SLOW_OUT && INT_ALLOW_OUT == 3'h7);
	endproperty
	a_rst: assert property (p_rst)
		else $error("normal mode not reached after reset");
	property p_norm;
		CPU_RUN_OUT && !CPU_CLK_SLOW_OUT |-> INT_SLOW_RC_EN_OUT &&
			INT_ALLOW_OUT == 3'h7 && EXT_INT_ALLOW_OUT;
	endproperty
	a_norm: assert property (p_norm)
		else $error("normal mode gating wrong");
	property p_pd_osc;
		!INT_SLOW_RC_EN_OUT |-> !EXT_FAST_OSC_EN_OUT && !INT_FAST_RC_EN_OUT;
	endproperty
	a_pd_osc: assert property (p_pd_osc)
		else $error("oscillator left on in power down");
	property p_pd_gate;
		!INT_SLOW_RC_EN_OUT |-> !CPU_RUN_OUT && PWM_RUN_OUT == 3'h0 &&
			INT_ALLOW_OUT == 3'h0 && !EXT_INT_ALLOW_OUT &&
			!CONVERTER_RUN_OUT && !BASIC_TIMER_RUN_OUT &&
			!TIMER_COUNTER_RUN_OUT;
	endproperty
	a_pd_gate: assert property (p_pd_gate)
		else $error("function left active in power down");
	property p_green;
		green |-> INT_ALLOW_OUT == 3'h1 && !CONVERTER_RUN_OUT &&
			INT_SLOW_RC_EN_OUT;
	endproperty
	a_green: assert property (p_green)
		else $error("green mode gating wrong");
	property p_gwake;
		green && BASIC_TIMER_OVF_IN |-> ##[1:3] CPU_RUN_OUT;
	endproperty
	a_gwake: assert property (p_gwake)
		else $error("green wake too slow");
	property p_slow;
		CPU_TICK_OUT && CPU_CLK_SLOW_OUT |=>
			(!CPU_TICK_OUT || !CPU_CLK_SLOW_OUT) [*7];
	endproperty
	a_slow: assert property (p_slow)
		else $error("slow ticks too close");
	property p_warm;
		wake_cnt != 16'h0000 && CPU_RUN_OUT |-> wake_cnt > 16'h0040;
	endproperty
	a_warm: assert property (p_warm)
		else $error("power down wake without warm up");
	c_gwake: cover property (green && BASIC_TIMER_OVF_IN);
	c_down: cover property ($fell(INT_SLOW_RC_EN_OUT));
	c_slow: cover property (CPU_TICK_OUT && CPU_CLK_SLOW_OUT);
endmodule
bind omc_top omc_top_chk u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
	.BASIC_TIMER_OVF_IN(BASIC_TIMER_OVF_IN), .CPU_RUN_OUT(CPU_RUN_OUT),
	.EXT_FAST_OSC_EN_OUT(EXT_FAST_OSC_EN_OUT), .PWM_RUN_OUT(PWM_RUN_OUT),
	.INT_FAST_RC_EN_OUT(INT_FAST_RC_EN_OUT), .CPU_TICK_OUT(CPU_TICK_OUT),
	.INT_SLOW_RC_EN_OUT(INT_SLOW_RC_EN_OUT), .INT_ALLOW_OUT(INT_ALLOW_OUT),
	.CPU_CLK_SLOW_OUT(CPU_CLK_SLOW_OUT), .CONVERTER_RUN_OUT(CONVERTER_RUN_OUT),
	.BASIC_TIMER_RUN_OUT(BASIC_TIMER_RUN_OUT),
	.TIMER_COUNTER_RUN_OUT(TIMER_COUNTER_RUN_OUT),
	.EXT_INT_ALLOW_OUT(EXT_INT_ALLOW_OUT));

// *** verification/operating_mode_controller_test.sv ***
/* Bench for omc_top: bus tasks, oscillator stand-ins, mode walk.
   Assumes a zero wait state slave; CE_IN held high. */
`timescale 1ns/10ps
module operating_mode_controller_test;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;}
		omc_row_s;
	logic CLK_IN = 1'b0, RST_B_IN = 1'b0, CE_IN = 1'b1, HSEL_IN = 1'b0;
	logic HWRITE_IN = 1'b0, BASIC_TIMER_OVF_IN = 1'b0, HREADY_IN;
	logic [31:0] HADDR_IN = 32'h0, HWDATA_IN = 32'h0, HRDATA_OUT;
	logic [1:0] HTRANS_IN = 2'h0, hdiv = 2'h0;
	logic [2:0] HSIZE_IN = 3'h2, PWM_RUN_OUT, INT_ALLOW_OUT, ldiv = 3'h0;
	logic HI_OSC_LVL_IN = 1'b0, LO_OSC_LVL_IN = 1'b0, HI_OSC_STABLE_IN = 1'b0;
	logic [7:0] P0_IN = 8'h00, hst = 8'h00;
	logic HREADYOUT_OUT, HRESP_OUT, EXT_FAST_OSC_EN_OUT, INT_FAST_RC_EN_OUT;
	logic INT_SLOW_RC_EN_OUT, CPU_RUN_OUT, CPU_CLK_SLOW_OUT, CPU_TICK_OUT;
	logic BASIC_TIMER_RUN_OUT, TIMER_COUNTER_RUN_OUT, CONVERTER_RUN_OUT;
	logic EXT_INT_ALLOW_OUT;
	logic [14:0] outs;
	int failures = 0, n_tests = 0, hedges = 0, ledges = 0, ticks = 0;
	omc_row_s rows [9] = '{'{1'b0, 8'h00, 32'h0, 32'h0},
		'{1'b0, 8'h04, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0},
		'{1'b0, 8'h0C, 32'h0, 32'h18}, '{1'b1, 8'h04, 32'hFFFFFFFF, 32'h7},
		'{1'b1, 8'h08, 32'hFFFFFFFF, 32'h3F},
		'{1'b1, 8'h10, 32'hFFFFFFFF, 32'h0},
		'{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h18}, '{1'b1, 8'h04, 32'h0, 32'h0}};
	assign HREADY_IN = HREADYOUT_OUT;
	assign outs = {EXT_FAST_OSC_EN_OUT, INT_FAST_RC_EN_OUT, INT_SLOW_RC_EN_OUT,
		CPU_RUN_OUT, CPU_CLK_SLOW_OUT, BASIC_TIMER_RUN_OUT,
		TIMER_COUNTER_RUN_OUT, PWM_RUN_OUT, CONVERTER_RUN_OUT, INT_ALLOW_OUT,
		EXT_INT_ALLOW_OUT};
	omc_top DUT (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
		.HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
		.HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN), .HWDATA_IN(HWDATA_IN),
		.HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HRESP_OUT(HRESP_OUT),
		.HREADYOUT_OUT(HREADYOUT_OUT), .HI_OSC_LVL_IN(HI_OSC_LVL_IN),
		.LO_OSC_LVL_IN(LO_OSC_LVL_IN), .HI_OSC_STABLE_IN(HI_OSC_STABLE_IN),
		.P0_IN(P0_IN), .BASIC_TIMER_OVF_IN(BASIC_TIMER_OVF_IN),
		.EXT_FAST_OSC_EN_OUT(EXT_FAST_OSC_EN_OUT), .CPU_RUN_OUT(CPU_RUN_OUT),
		.INT_FAST_RC_EN_OUT(INT_FAST_RC_EN_OUT), .CPU_TICK_OUT(CPU_TICK_OUT),
		.INT_SLOW_RC_EN_OUT(INT_SLOW_RC_EN_OUT), .PWM_RUN_OUT(PWM_RUN_OUT),
		.CPU_CLK_SLOW_OUT(CPU_CLK_SLOW_OUT), .INT_ALLOW_OUT(INT_ALLOW_OUT),
		.BASIC_TIMER_RUN_OUT(BASIC_TIMER_RUN_OUT),
		.TIMER_COUNTER_RUN_OUT(TIMER_COUNTER_RUN_OUT),
		.CONVERTER_RUN_OUT(CONVERTER_RUN_OUT),
		.EXT_INT_ALLOW_OUT(EXT_INT_ALLOW_OUT));
	always #5 CLK_IN = ~CLK_IN;
	// Oscillators stand still while their enables are low
	always @(posedge CLK_IN) begin
		if (!(EXT_FAST_OSC_EN_OUT || INT_FAST_RC_EN_OUT)) begin
			hdiv <= 2'h0;
			hst <= 8'h00;
			HI_OSC_LVL_IN <= 1'b0;
		end else begin
			hdiv <= (hdiv == 2'h2) ? 2'h0 : hdiv + 2'h1;
			hst <= (hst == 8'hFF) ? hst : hst + 8'h01;
			if (hdiv == 2'h2)
				HI_OSC_LVL_IN <= ~HI_OSC_LVL_IN;
			if (hdiv == 2'h2 && !HI_OSC_LVL_IN && HI_OSC_STABLE_IN)
				hedges <= hedges + 1;
		end
		HI_OSC_STABLE_IN <= hst > 8'h14;
		ldiv <= (ldiv == 3'h4) ? 3'h0 : ldiv + 3'h1;
		if (!INT_SLOW_RC_EN_OUT)
			LO_OSC_LVL_IN <= 1'b0;
		else if (ldiv == 3'h4)
			LO_OSC_LVL_IN <= ~LO_OSC_LVL_IN;
		if (ldiv == 3'h4 && !LO_OSC_LVL_IN && INT_SLOW_RC_EN_OUT)
			ledges <= ledges + 1;
		if (CPU_TICK_OUT === 1'b1)
			ticks <= ticks + 1;
	end
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_IN);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		HSEL_IN <= 1'b1;
		HTRANS_IN <= 2'h2;
		HWRITE_IN <= w;
		HADDR_IN <= {24'h000000, a};
		do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
		HSEL_IN <= 1'b0;
		HTRANS_IN <= 2'h0;
		HWDATA_IN <= d;
		do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
		r = HRDATA_OUT;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] m);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(nm, r & m, e);
	endtask
	task automatic rate(input string nm, input int dv);
		int e0, t0;
		e0 = (dv == 4) ? ledges : hedges;
		t0 = ticks;
		cyc(400);
		e0 = ((dv == 4) ? ledges : hedges) - e0;
		t0 = ticks - t0;
		chk(nm, 32'(t0 * dv >= e0 - dv && t0 * dv <= e0 + dv), 32'h1);
	endtask
	// Counts fast edges between P0 change and CPU restart
	task automatic wake_p0(input int n);
		int e0, i;
		e0 = hedges;
		i = 0;
		P0_IN <= P0_IN ^ 8'h08;
		while (CPU_RUN_OUT !== 1'b1 && i < 20000) begin
			@(posedge CLK_IN);
			i++;
		end
		e0 = hedges - e0;
		chk("wake_run", {31'h0, CPU_RUN_OUT}, 32'h1);
		chk("warm_edges", 32'(e0 >= n - 1 && e0 <= n + 2), 32'h1);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		cyc(5);
		RST_B_IN <= 1'b1;
		cyc(6);
		chk("reset_outs", {17'h0, outs}, 32'h380F);
		for (int i = 0; i < 9; i++) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rdc("row", rows[i].a, rows[i].e, 32'hFFFFFFFF);
		end
		wr(8'h00, 32'h10);
		cyc(4);
		chk("green_outs", {17'h0, outs}, 32'h33E3);
		rdc("green_stat", 8'h0C, 32'h02, 32'h0F);
		BASIC_TIMER_OVF_IN <= 1'b1;
		cyc(1);
		BASIC_TIMER_OVF_IN <= 1'b0;
		cyc(3);
		chk("green_wake", {17'h0, outs}, 32'h3BFF);
		rdc("green_clr", 8'h00, 32'h0, 32'hFF);
		rdc("gwake_src", 8'h0C, 32'h80, 32'hC0);
		rate("norm_tick", 1);
		wr(8'h00, 32'h08);
		cyc(4);
		chk("down_outs", {17'h0, outs}, 32'h0);
		rdc("down_stat", 8'h0C, 32'h01, 32'h3F);
		BASIC_TIMER_OVF_IN <= 1'b1;
		cyc(1);
		BASIC_TIMER_OVF_IN <= 1'b0;
		cyc(8);
		chk("down_hold", {17'h0, outs}, 32'h0);
		wake_p0(32);
		rdc("down_clr", 8'h00, 32'h0, 32'hFF);
		rdc("wake_src", 8'h0C, 32'h58, 32'h7F);
		wr(8'h04, 32'h2);
		cyc(300);
		wr(8'h00, 32'h02);
		cyc(4);
		chk("stop_norm", {17'h0, outs}, 32'h0);
		wake_p0(2048);
		rdc("stop_clr", 8'h00, 32'h0, 32'hFF);
		wr(8'h04, 32'h0);
		cyc(300);
		wr(8'h00, 32'h04);
		cyc(4);
		chk("slow_outs", {17'h0, outs}, 32'h3FFF);
		rate("slow_tick", 4);
		wr(8'h00, 32'h06);
		cyc(4);
		chk("slow_stop", {17'h0, outs}, 32'h1FFF);
		wr(8'h00, 32'h16);
		cyc(4);
		chk("green_slow", {17'h0, outs}, 32'h17E3);
		P0_IN <= P0_IN ^ 8'h80;
		cyc(8);
		chk("gs_wake", {17'h0, outs}, 32'h1FFF);
		rdc("gs_mode", 8'h00, 32'h06, 32'hFF);
		wr(8'h00, 32'h04);
		cyc(300);
		wr(8'h00, 32'h00);
		cyc(4);
		chk("back_norm", {17'h0, outs}, 32'h3BFF);
		wr(8'h00, 32'h04);
		cyc(4);
		RST_B_IN <= 1'b0;
		cyc(2);
		chk("rst_outs", {17'h0, outs}, 32'h3000);
		chk("rst_bus", {30'h0, HRESP_OUT, HREADYOUT_OUT}, 32'h1);
		RST_B_IN <= 1'b1;
		cyc(6);
		chk("rst_norm", {17'h0, outs}, 32'h380F);
		rdc("rst_mode", 8'h00, 32'h0, 32'hFF);
		final_report;
	end
	initial begin
		repeat (40000) @(posedge CLK_IN);
		failures++;
		$display("[ERR] watchdog expected end seen timeout");
		final_report;
	end
endmodule
